// ==== hw/smst_status_tracker.sv ====
// Purpose: Tracks the bus protocol state and presents its code.
// Assumes: Controller core reports its own START, arbitration loss, end.
// Notes: Code register is read only on the special function port.
`timescale 1ns/1ns
`default_nettype none
module smst_status_tracker (
   // System clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Link clock and bus pins
   input wire logic i_link_clk,
   input wire logic i_scl,
   input wire logic i_sda,
   // Special function register read port
   input wire logic [7:0] i_sfr_addr,
   input wire logic i_sfr_rd,
   output logic [7:0] o_sfr_rdata,
   // Controller core events
   input wire logic i_begin_sent,
   input wire logic i_arb_lost,
   input wire logic i_end_condition_request,
   // Control bits
   input wire logic i_acknowledge_level_select,
   input wire logic i_gc_enable,
   input wire logic [6:0] i_own_addr,
   input wire logic i_free_timer_en,
   input wire logic [7:0] i_clock_rate_preset,
   input wire logic i_irq_pending_clr,
   // Status
   output logic o_irq_pending,
   output logic [7:0] o_bus_condition_code
);
   typedef enum logic [3:0] {
      ST_IDLE, ST_MADDR, ST_MTX, ST_MRX, ST_SADDR,
      ST_SRX, ST_SGC, ST_STX, ST_SLAST, ST_WAIT
   } smst_role_e;

   smst_role_e role_q;
   smst_role_e role_d;
   logic [7:0] code_q;
   logic [7:0] code_d;
   logic upd;
   logic si_q;
   logic arb_q;
   logic arb_d;
   logic ev_tgl;
   smst_pkg::smst_ev_e ev_kind;
   logic [7:0] ev_data;
   logic ev_ack;
   logic scl_lvl;
   logic tgl_s;
   logic tgl_d_q;
   logic scl_hi;
   logic ev_vld_q;
   smst_pkg::smst_ev_e ev_kind_q;
   logic [7:0] ev_data_q;
   logic ev_ack_q;
   logic ev_start;
   logic ev_stop;
   logic ev_byte;
   logic ev_err;
   logic [7:0] tmr_q;
   logic tmr_done_q;
   logic tmr_run;
   logic tmo;
   logic is_master;
   logic is_slave;
   logic arb_take;
   logic hi_prio;

   function automatic logic [7:0] pick(input logic ack, input logic [7:0] a,
                                       input logic [7:0] n);
      pick = ack ? a : n;
   endfunction

   smst_link_mon u_mon (
      .i_link_clk(i_link_clk),
      .i_rst(i_rst),
      .i_scl(i_scl),
      .i_sda(i_sda),
      .o_ev_tgl(ev_tgl),
      .o_ev_kind(ev_kind),
      .o_ev_data(ev_data),
      .o_ev_ack(ev_ack),
      .o_scl_lvl(scl_lvl)
   );

   smst_sync #(.STAGES(smst_pkg::SYNC_STAGES)) u_tgl_sync (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_d(ev_tgl),
      .o_q(tgl_s)
   );

   smst_sync #(.STAGES(smst_pkg::SYNC_STAGES)) u_scl_sync (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_d(scl_lvl),
      .o_q(scl_hi)
   );

   // Event capture; payload is stable well before the toggle arrives
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         tgl_d_q <= 1'b0;
         ev_vld_q <= 1'b0;
         ev_kind_q <= smst_pkg::EV_STOP;
         ev_data_q <= 8'h00;
         ev_ack_q <= 1'b0;
      end else begin
         tgl_d_q <= tgl_s;
         ev_vld_q <= tgl_s ^ tgl_d_q;
         if (tgl_s ^ tgl_d_q) begin
            ev_kind_q <= ev_kind;
            ev_data_q <= ev_data;
            ev_ack_q <= ev_ack;
         end
      end
   end

   assign ev_start = ev_vld_q && ev_kind_q == smst_pkg::EV_START;
   assign ev_stop = ev_vld_q && ev_kind_q == smst_pkg::EV_STOP;
   assign ev_byte = ev_vld_q && ev_kind_q == smst_pkg::EV_BYTE;
   assign ev_err = ev_vld_q && ev_kind_q == smst_pkg::EV_ERR;

   // SCL high timer, preloaded while SCL is low
   assign tmr_run = scl_hi && i_free_timer_en && role_q != ST_IDLE;
   assign tmo = tmr_run && !tmr_done_q && tmr_q == smst_pkg::TMR_TOP;

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         tmr_q <= 8'h00;
         tmr_done_q <= 1'b0;
      end else if (!tmr_run) begin
         tmr_q <= i_clock_rate_preset; // RULE18
         tmr_done_q <= 1'b0;
      end else if (!tmr_done_q) begin
         tmr_q <= tmr_q + 8'h01;
         tmr_done_q <= tmo;
      end
   end

   assign is_master = role_q inside {ST_MADDR, ST_MTX, ST_MRX};
   assign is_slave = role_q inside {ST_SRX, ST_SGC, ST_STX, ST_SLAST};
   assign arb_take = i_arb_lost && is_master;
   assign hi_prio = ev_err || tmo || arb_take || i_begin_sent || i_end_condition_request;

   // Next state and code; error, timeout, arbitration, core, bus in turn
   always_comb begin
      role_d = role_q;
      code_d = code_q;
      arb_d = arb_q;
      upd = 1'b0;
      if (ev_err) begin
         code_d = smst_pkg::C_BUS_ERR; // RULE19
         role_d = ST_IDLE;
         arb_d = 1'b0;
         upd = 1'b1;
      end else if (tmo) begin
         code_d = smst_pkg::C_TIMEOUT; // RULE18
         upd = 1'b1;
      end else if (arb_take) begin
         code_d = smst_pkg::C_ARB_LOST; // RULE12
         arb_d = role_q == ST_MADDR;
         role_d = ST_SADDR;
         upd = 1'b1;
      end else if (i_begin_sent) begin
         code_d = is_master ? smst_pkg::C_RSTART : smst_pkg::C_START; // RULE6
         role_d = ST_MADDR;
         upd = 1'b1;
      end else if (i_end_condition_request) begin
         code_d = smst_pkg::C_IDLE;
         role_d = ST_IDLE;
         arb_d = 1'b0;
         upd = 1'b1;
      end else if (ev_start) begin
         if (is_slave) begin
            code_d = smst_pkg::C_S_END; // RULE15
            upd = 1'b1;
         end
         if (!is_master) role_d = ST_SADDR;
      end else if (ev_stop) begin
         code_d = is_slave ? smst_pkg::C_S_END : smst_pkg::C_IDLE; // RULE15
         upd = is_slave || is_master;
         role_d = ST_IDLE;
         arb_d = 1'b0;
      end else if (ev_byte) begin
         upd = 1'b1;
         case (role_q)
            ST_MADDR: begin
               if (ev_data_q[0]) begin
                  code_d = pick(ev_ack_q, smst_pkg::C_MR_AR_ACK, smst_pkg::C_MR_AR_NACK); // RULE9
                  role_d = ST_MRX;
               end else begin
                  // RULE7 RULE23
                  code_d = pick(ev_ack_q, smst_pkg::C_MT_AW_ACK, smst_pkg::C_MT_AW_NACK);
                  role_d = ST_MTX;
               end
            end
            ST_MTX: code_d = pick(ev_ack_q, smst_pkg::C_MT_D_ACK, smst_pkg::C_MT_D_NACK); // RULE8
            ST_MRX: code_d = pick(ev_ack_q, smst_pkg::C_MR_D_ACK, smst_pkg::C_MR_D_NACK); // RULE10
            ST_SADDR: begin
               arb_d = 1'b0;
               role_d = ST_WAIT;
               upd = 1'b0;
               if (!i_acknowledge_level_select) begin
                  role_d = ST_WAIT;
               end else if (ev_data_q[7:1] == i_own_addr && !ev_data_q[0]) begin
                  code_d = arb_q ? smst_pkg::C_SR_AW_ARB : smst_pkg::C_SR_AW; // RULE11 RULE12
                  role_d = ST_SRX;
                  upd = 1'b1;
               end else if (ev_data_q[7:1] == i_own_addr) begin
                  code_d = arb_q ? smst_pkg::C_ST_AR_ARB : smst_pkg::C_ST_AR; // RULE16 RULE12
                  role_d = ST_STX;
                  upd = 1'b1;
               end else if (ev_data_q == smst_pkg::GC_ADDR && i_gc_enable) begin
                  code_d = arb_q ? smst_pkg::C_SR_GC_ARB : smst_pkg::C_SR_GC; // RULE11 RULE12
                  role_d = ST_SGC;
                  upd = 1'b1;
               end
            end
            ST_SRX: code_d = pick(ev_ack_q, smst_pkg::C_SR_D_ACK, smst_pkg::C_SR_D_NACK); // RULE13
            ST_SGC: code_d = pick(ev_ack_q, smst_pkg::C_GC_D_ACK, smst_pkg::C_GC_D_NACK); // RULE14
            ST_STX: begin
               if (!ev_ack_q) begin
                  code_d = smst_pkg::C_ST_D_NACK; // RULE16
                  role_d = ST_WAIT;
               end else if (!i_acknowledge_level_select) begin
                  code_d = smst_pkg::C_ST_LAST; // RULE17
                  role_d = ST_SLAST;
               end else begin
                  code_d = smst_pkg::C_ST_D_ACK; // RULE16
               end
            end
            default: upd = 1'b0;
         endcase
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         role_q <= ST_IDLE;
         arb_q <= 1'b0;
      end else begin
         role_q <= role_d;
         arb_q <= arb_d;
      end
   end

   // Code register; codes are all multiples of eight
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         code_q <= smst_pkg::CODE_RESET; // RULE5
      end else if (upd) begin
         code_q <= code_d; // RULE1 RULE2
      end
   end

   // Pending flag; a new state wins over a clear in the same cycle
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         si_q <= 1'b0;
      end else if (upd && code_d != smst_pkg::C_IDLE) begin
         si_q <= 1'b1; // RULE22 RULE5
      end else if (i_irq_pending_clr) begin
         si_q <= 1'b0; // RULE22
      end
   end

   // Read port; the code is read only, writes are not decoded
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_sfr_rdata <= 8'h00;
      end else if (i_sfr_rd) begin
         o_sfr_rdata <= (i_sfr_addr == smst_pkg::SFR_BUS_COND) ? code_q : 8'h00; // RULE4
      end
   end

   assign o_irq_pending = si_q;
   assign o_bus_condition_code = code_q;

   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);

   code_mult8_a: // RULE2
   assert property (si_q |-> code_q[2:0] == 3'h0)
      else $error("code low bits not zero while pending");
   idle_no_si_a: // RULE5
   assert property ($rose(si_q) |-> code_q != smst_pkg::C_IDLE)
      else $error("pending flag raised by idle code");
   si_sticky_a: // RULE22
   assert property (si_q && !i_irq_pending_clr |=> si_q)
      else $error("pending flag dropped without software clear");
   start_code_a: // RULE6
   assert property (i_begin_sent && !ev_err && !tmo && !arb_take && role_q == ST_IDLE
                    |=> code_q == smst_pkg::C_START && si_q)
      else $error("START not reported as 0x08");
   rstart_code_a: // RULE6
   assert property (i_begin_sent && !ev_err && !tmo && !arb_take && role_q == ST_MTX
                    |=> code_q == smst_pkg::C_RSTART && role_q == ST_MADDR && si_q)
      else $error("repeated START not reported as 0x10");
   mtx_data_a: // RULE8
   assert property (ev_byte && !hi_prio && role_q == ST_MTX
                    |=> code_q == ($past(ev_ack_q) ? smst_pkg::C_MT_D_ACK : smst_pkg::C_MT_D_NACK))
      else $error("wrong master transmit data code");
   mrx_data_a: // RULE10
   assert property (ev_byte && !hi_prio && role_q == ST_MRX
                    |=> code_q == ($past(ev_ack_q) ? smst_pkg::C_MR_D_ACK : smst_pkg::C_MR_D_NACK))
      else $error("wrong master receive data code");
   srx_data_a: // RULE13
   assert property (ev_byte && !hi_prio && role_q == ST_SRX
                    |=> code_q == ($past(ev_ack_q) ? smst_pkg::C_SR_D_ACK : smst_pkg::C_SR_D_NACK))
      else $error("wrong slave receive data code");
   arb_lost_a: // RULE12
   assert property (arb_take && !ev_err && !tmo
                    |=> code_q == smst_pkg::C_ARB_LOST && role_q == ST_SADDR && si_q)
      else $error("arbitration loss not reported as 0x38");
   timeout_code_a: // RULE18
   assert property (tmo && !ev_err |=> code_q == smst_pkg::C_TIMEOUT && si_q)
      else $error("timeout not reported as 0xd0");
   bus_err_a: // RULE19
   assert property (ev_err |=> code_q == smst_pkg::C_BUS_ERR && role_q == ST_IDLE && si_q)
      else $error("bus error not reported as 0x00");
   rd_port_a: // RULE1
   assert property (i_sfr_rd && i_sfr_addr == smst_pkg::SFR_BUS_COND
                    |=> o_sfr_rdata == $past(code_q))
      else $error("read port does not return the code");
endmodule
`default_nettype wire

// ==== common/smst_pkg.sv ====
// Purpose: Shared constants for the bus condition code tracker.
// Assumes: 8-bit special function register port, byte wide codes.
// Notes: Behaviour list below.
// Behaviour
// RULE1: Keep one 8-bit code register, one unique code per each of 28 states.
// RULE2: While the pending flag is set, the low three code bits read zero.
// RULE3: Software trusts the code only while the pending flag is one.
// RULE4: Software never writes the code register; such a write has no defined effect.
// RULE5: Reset code is 0xf8; entering idle never raises the pending flag.
// RULE6: Master reports 0x08 after START, 0x10 after repeated START.
// RULE7: Master transmitter reports 0x18 when address plus write is acknowledged.
// RULE8: Master transmitter data byte: 0x28 acknowledged, 0x30 not acknowledged.
// RULE9: Master receiver address plus read: 0x40 acknowledged, 0x48 not acknowledged.
// RULE10: Master receiver data byte: 0x50 ack returned, 0x58 not-ack returned.
// RULE11: Slave reports 0x60 for own address plus write, 0x70 for general call.
// RULE12: Lost arbitration gives 0x38; then addressed gives 0x68, 0x78 or 0xb0. Code does so only after a loss during the address byte.
// RULE13: Addressed slave receiver data byte: 0x80 acknowledged, 0x88 not acknowledged.
// RULE14: Data after general call: 0x90 acknowledged, 0x98 not acknowledged.
// RULE15: As slave, a STOP or repeated START on the bus reports 0xa0.
// RULE16: Slave transmitter: 0xa8 addressed for read, 0xb8 byte acked, 0xc0 byte not acked.
// RULE17: Slave transmitter with acknowledge level cleared, last byte acked, reports 0xc8.
// RULE18: SCL high timer preloaded from clock rate preset reports 0xd0 on timeout.
// RULE19: START or STOP in an illegal position reports bus error 0x00.
// RULE20: Software should request an end condition after errors, timeouts and such.
// RULE21: Master receiver software clears acknowledge level before the final byte.
// RULE22: Every non-idle state entry sets the pending flag; only software clears it.
// RULE23: Master transmitter reports 0x20 when address plus write is not acknowledged.
package smst_pkg;
   localparam logic [7:0] SFR_BUS_COND = 8'hc1;
   localparam int SYNC_STAGES = 3;
   localparam int PIN_STAGES = 3;
   localparam logic [3:0] BIT_LAST = 4'h8;
   localparam logic [3:0] BIT_LEGAL_MAX = 4'h1;
   localparam logic [7:0] TMR_TOP = 8'hff;
   localparam logic [7:0] GC_ADDR = 8'h00;
   // Status codes
   localparam logic [7:0] C_START = 8'h08;
   localparam logic [7:0] C_RSTART = 8'h10;
   localparam logic [7:0] C_MT_AW_ACK = 8'h18;
   localparam logic [7:0] C_MT_AW_NACK = 8'h20;
   localparam logic [7:0] C_MT_D_ACK = 8'h28;
   localparam logic [7:0] C_MT_D_NACK = 8'h30;
   localparam logic [7:0] C_ARB_LOST = 8'h38;
   localparam logic [7:0] C_MR_AR_ACK = 8'h40;
   localparam logic [7:0] C_MR_AR_NACK = 8'h48;
   localparam logic [7:0] C_MR_D_ACK = 8'h50;
   localparam logic [7:0] C_MR_D_NACK = 8'h58;
   localparam logic [7:0] C_SR_AW = 8'h60;
   localparam logic [7:0] C_SR_AW_ARB = 8'h68;
   localparam logic [7:0] C_SR_GC = 8'h70;
   localparam logic [7:0] C_SR_GC_ARB = 8'h78;
   localparam logic [7:0] C_SR_D_ACK = 8'h80;
   localparam logic [7:0] C_SR_D_NACK = 8'h88;
   localparam logic [7:0] C_GC_D_ACK = 8'h90;
   localparam logic [7:0] C_GC_D_NACK = 8'h98;
   localparam logic [7:0] C_S_END = 8'ha0;
   localparam logic [7:0] C_ST_AR = 8'ha8;
   localparam logic [7:0] C_ST_AR_ARB = 8'hb0;
   localparam logic [7:0] C_ST_D_ACK = 8'hb8;
   localparam logic [7:0] C_ST_D_NACK = 8'hc0;
   localparam logic [7:0] C_ST_LAST = 8'hc8;
   localparam logic [7:0] C_TIMEOUT = 8'hd0;
   localparam logic [7:0] C_BUS_ERR = 8'h00;
   localparam logic [7:0] C_IDLE = 8'hf8;
   localparam logic [7:0] CODE_RESET = C_IDLE;
   typedef enum logic [1:0] {EV_START, EV_STOP, EV_BYTE, EV_ERR} smst_ev_e;
endpackage

// ==== hw/smst_sync.sv ====
// Purpose: Level synchroniser chain into the system clock domain.
// Assumes: Input is a slow level or a toggle.
// Notes: Output follows once the last two stages agree.
`timescale 1ns/1ns
`default_nettype none
module smst_sync #(
   parameter int STAGES = 2
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Level in and out
   input wire logic i_d,
   output logic o_q
);
   logic [STAGES-1:0] chain_q;
   logic lvl_q;

   // A change counts once the last two stages agree
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         chain_q <= '0;
         lvl_q <= 1'b0;
      end else begin
         chain_q <= {chain_q[STAGES-2:0], i_d};
         if (chain_q[STAGES-2] == chain_q[STAGES-1]) lvl_q <= chain_q[STAGES-1];
      end
   end

   assign o_q = lvl_q;
endmodule
`default_nettype wire

// ==== hw/smst_link_mon.sv ====
// Purpose: Bus monitor on the link clock; finds START, STOP and bytes.
// Assumes: Link clock oversamples SCL and SDA several times per bit.
// Notes: Each event flips a toggle; kind and data are held with it.
`timescale 1ns/1ns
`default_nettype none
module smst_link_mon (
   // Clock and reset
   input wire logic i_link_clk,
   input wire logic i_rst,
   // Bus pins
   input wire logic i_scl,
   input wire logic i_sda,
   // Event to the system domain
   output logic o_ev_tgl,
   output smst_pkg::smst_ev_e o_ev_kind,
   output logic [7:0] o_ev_data,
   output logic o_ev_ack,
   output logic o_scl_lvl
);
   logic [smst_pkg::PIN_STAGES-1:0] scl_s_q;
   logic [smst_pkg::PIN_STAGES-1:0] sda_s_q;
   logic scl_q;
   logic sda_q;
   logic scl_p_q;
   logic sda_p_q;
   logic [3:0] bit_cnt_q;
   logic [7:0] shift_q;
   logic start_ev;
   logic stop_ev;
   logic scl_rise;

   // Pin synchronisers; a level counts once stages two and three agree
   always_ff @(posedge i_link_clk or posedge i_rst) begin
      if (i_rst) begin
         scl_s_q <= '1;
         sda_s_q <= '1;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else begin
         scl_s_q <= {scl_s_q[1:0], i_scl};
         sda_s_q <= {sda_s_q[1:0], i_sda};
         if (scl_s_q[1] == scl_s_q[2]) scl_q <= scl_s_q[2];
         if (sda_s_q[1] == sda_s_q[2]) sda_q <= sda_s_q[2];
         scl_p_q <= scl_q;
         sda_p_q <= sda_q;
      end
   end

   assign start_ev = scl_q && scl_p_q && sda_p_q && !sda_q;
   assign stop_ev = scl_q && scl_p_q && !sda_p_q && sda_q;
   assign scl_rise = scl_q && !scl_p_q;
   assign o_scl_lvl = scl_q;

   always_ff @(posedge i_link_clk or posedge i_rst) begin
      if (i_rst) begin
         bit_cnt_q <= 4'h0;
         shift_q <= 8'h00;
         o_ev_tgl <= 1'b0;
         o_ev_kind <= smst_pkg::EV_STOP;
         o_ev_data <= 8'h00;
         o_ev_ack <= 1'b0;
      end else if (start_ev || stop_ev) begin
         bit_cnt_q <= 4'h0;
         o_ev_tgl <= !o_ev_tgl;
         // Mid-byte condition is a bus error
         if (bit_cnt_q > smst_pkg::BIT_LEGAL_MAX) begin
            o_ev_kind <= smst_pkg::EV_ERR; // RULE19
         end else if (start_ev) begin
            o_ev_kind <= smst_pkg::EV_START;
         end else begin
            o_ev_kind <= smst_pkg::EV_STOP;
         end
      end else if (scl_rise) begin
         if (bit_cnt_q == smst_pkg::BIT_LAST) begin
            bit_cnt_q <= 4'h0;
            o_ev_tgl <= !o_ev_tgl;
            o_ev_kind <= smst_pkg::EV_BYTE;
            o_ev_data <= shift_q;
            o_ev_ack <= !sda_q;
         end else begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
            shift_q <= {shift_q[6:0], sda_q};
         end
      end
   end
endmodule
`default_nettype wire

// ==== verification/smst_bus_model.sv ====
// Purpose: Other bus party driving SCL and SDA.
// Assumes: Open drain lines with pull-ups; a released line reads high.
// Notes: SDA moves only while SCL is low, except in conditions.
`timescale 1ns/1ns
`default_nettype none
module smst_bus_model #(
   parameter int HALF = 4
) (
   // Link clock
   input wire logic i_link_clk,
   // Bus lines
   output logic o_scl,
   output logic o_sda
);
   initial begin
      o_scl = 1'b1;
      o_sda = 1'b1;
   end
   task automatic hw(input logic c, input logic d);
      o_scl <= c;
      o_sda <= d;
      repeat (HALF) @(posedge i_link_clk);
   endtask
   task automatic start();
      hw(1'b1, 1'b1);
      hw(1'b1, 1'b0);
   endtask
   // Repeated start ends with SDA falling, stop with SDA rising
   task automatic cond(input logic rep);
      hw(1'b0, o_sda);
      hw(1'b0, rep);
      hw(1'b1, rep);
      hw(1'b1, ~rep);
   endtask
   task automatic bits(input logic [8:0] v, input int n);
      for (int i = 8; i > 8 - n; i--) begin
         hw(1'b0, o_sda);
         hw(1'b0, v[i]);
         hw(1'b1, v[i]);
      end
      hw(1'b0, o_sda);
      hw(1'b0, 1'b1);
   endtask
endmodule
`default_nettype wire

// ==== verification/tb.sv ====
// Purpose: Self-checking bench for the bus condition code tracker.
// Assumes: The bus model plays the other masters and slaves.
// Notes: A row is kind, byte, ack level and ack, expected code.
// Notes: Ack low on a non-byte row means no new code and no flag.
`timescale 1ns/1ns
`default_nettype none
module tb;
   localparam logic [2:0] BG = 3'h0, SA = 3'h1, BY = 3'h2, SP = 3'h3;
   localparam logic [2:0] AL = 3'h4, EN = 3'h5, RS = 3'h6;
   logic i_clk = 1'b0, i_link_clk = 1'b0, i_rst = 1'b1;
   logic clr = 1'b0, ten = 1'b0, als = 1'b1, sfr_rd = 1'b0, gce = 1'b1;
   logic [2:0] ev = 3'h0;
   logic [7:0] sfr_addr = 8'h00, preset = 8'h00;
   wire scl, sda, pend;
   wire [7:0] rdata, code;
   int err_total = 0;
   int total_checks = 0;
   int n;
   logic [20:0] rows [45] = '{
      {AL,8'h00,2'b11,8'hf8}, {SA,8'h00,2'b11,8'h00}, {BY,8'h54,2'b11,8'h60},
      {BY,8'h11,2'b11,8'h80}, {BY,8'h22,2'b10,8'h88}, {SP,8'h00,2'b11,8'ha0},
      {SA,8'h00,2'b11,8'h00}, {BY,8'h00,2'b11,8'h70}, {BY,8'h33,2'b11,8'h90},
      {BY,8'h44,2'b10,8'h98}, {RS,8'h00,2'b11,8'ha0}, {BY,8'h55,2'b11,8'ha8},
      {BY,8'h66,2'b11,8'hb8}, {BY,8'h77,2'b10,8'hc0}, {SP,8'h00,2'b10,8'hc0},
      {SA,8'h00,2'b11,8'h00}, {BY,8'h55,2'b11,8'ha8}, {BY,8'h88,2'b01,8'hc8},
      {SP,8'h00,2'b11,8'ha0}, {BG,8'h00,2'b11,8'h08}, {BY,8'ha0,2'b11,8'h18},
      {BY,8'h12,2'b11,8'h28}, {BY,8'h34,2'b10,8'h30}, {BG,8'h00,2'b11,8'h10},
      {BY,8'ha0,2'b10,8'h20}, {SP,8'h00,2'b11,8'hf8}, {BG,8'h00,2'b11,8'h08},
      {BY,8'ha1,2'b11,8'h40}, {BY,8'h5a,2'b11,8'h50}, {BY,8'ha5,2'b00,8'h58},
      {BG,8'h00,2'b11,8'h10}, {BY,8'ha1,2'b10,8'h48}, {SP,8'h00,2'b11,8'hf8},
      {BG,8'h00,2'b11,8'h08}, {AL,8'h00,2'b11,8'h38}, {BY,8'h54,2'b11,8'h68},
      {SP,8'h00,2'b11,8'ha0}, {BG,8'h00,2'b11,8'h08}, {AL,8'h00,2'b11,8'h38},
      {BY,8'h00,2'b11,8'h78}, {SP,8'h00,2'b11,8'ha0}, {BG,8'h00,2'b11,8'h08},
      {AL,8'h00,2'b11,8'h38}, {BY,8'h55,2'b11,8'hb0}, {SP,8'h00,2'b11,8'ha0}
   };
   smst_bus_model smst_bus_model_i (.i_link_clk(i_link_clk), .o_scl(scl), .o_sda(sda));
   smst_status_tracker smst_status_tracker_i (
      .i_clk(i_clk), .i_rst(i_rst), .i_link_clk(i_link_clk), .i_scl(scl), .i_sda(sda),
      .i_sfr_addr(sfr_addr), .i_sfr_rd(sfr_rd), .o_sfr_rdata(rdata),
      .i_begin_sent(ev[0]), .i_arb_lost(ev[1]), .i_end_condition_request(ev[2]),
      .i_acknowledge_level_select(als), .i_gc_enable(gce), .i_own_addr(7'h2a),
      .i_free_timer_en(ten), .i_clock_rate_preset(preset), .i_irq_pending_clr(clr),
      .o_irq_pending(pend), .o_bus_condition_code(code));
   initial begin
      forever #25 i_clk = ~i_clk;
   end
   initial begin
      #37;
      forever #80 i_link_clk = ~i_link_clk;
   end
   task automatic close_out();
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
      total_checks++;
      if (g !== e) begin
         err_total++;
         $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic wait_pend(input int lim);
      n = 0;
      while (pend !== 1'b1 && n < lim) begin
         @(negedge i_clk);
         n++;
      end
      if (n >= lim) begin
         err_total++;
         $display("FAIL t=%0t waited=%h limit=%h", $time, n, lim);
         close_out();
      end
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      @(posedge i_clk);
      sfr_addr <= a;
      sfr_rd <= 1'b1;
      @(posedge i_clk);
      sfr_rd <= 1'b0;
      @(negedge i_clk);
      cmp8(rdata, e);
   endtask
   // Clear the flag, apply one step, then check flag, code unless SA, and read port if flagged
   task automatic run_row(input logic [20:0] r);
      logic p;
      p = r[20:18] != SA && r[7:0] != 8'hf8 && (r[20:18] == BY || r[8]);
      @(posedge i_clk);
      clr <= 1'b1;
      als <= r[9];
      @(posedge i_clk);
      clr <= 1'b0;
      case (r[20:18])
         SA: smst_bus_model_i.start();
         BY: smst_bus_model_i.bits({r[17:10], ~r[8]}, 9);
         SP: smst_bus_model_i.cond(1'b0);
         RS: smst_bus_model_i.cond(1'b1);
         default: begin
            ev <= (r[20:18] == BG) ? 3'h1 : (r[20:18] == AL) ? 3'h2 : 3'h4;
            @(posedge i_clk);
            ev <= 3'h0;
         end
      endcase
      if (p) wait_pend(200);
      repeat (40) @(posedge i_clk);
      @(negedge i_clk);
      cmp8({7'h0, pend}, {7'h0, p});
      if (r[20:18] != SA) cmp8(code, r[7:0]);
      if (p) rd_chk(smst_pkg::SFR_BUS_COND, r[7:0]);
   endtask
   initial begin
      repeat (2) @(posedge i_clk);
      repeat (4) @(posedge i_link_clk);
      @(posedge i_clk);
      i_rst <= 1'b0;
      @(negedge i_clk);
      cmp8(code, 8'hf8);
      cmp8(rdata, 8'h00);
      foreach (rows[i]) begin
         run_row(rows[i]);
      end
      rd_chk(8'hc0, 8'h00);
      // General call ignored while recognition is off
      @(posedge i_clk);
      gce <= 1'b0;
      run_row({SA, 8'h00, 2'b11, 8'h00});
      smst_bus_model_i.bits(9'h001, 9);
      repeat (40) @(posedge i_clk);
      @(negedge i_clk);
      cmp8({7'h0, pend}, 8'h00);
      cmp8(code, 8'ha0);
      @(posedge i_clk);
      gce <= 1'b1;
      // Stop after three bits of the address byte
      run_row({SA, 8'h00, 2'b11, 8'h00});
      smst_bus_model_i.bits(9'h0ff, 3);
      smst_bus_model_i.cond(1'b0);
      wait_pend(200);
      @(negedge i_clk);
      cmp8(code, 8'h00);
      run_row({EN, 8'h00, 2'b11, 8'hf8});
      run_row({BG, 8'h00, 2'b11, 8'h08});
      // SCL held high in master role with a short preset
      @(posedge i_clk);
      clr <= 1'b1;
      preset <= 8'hf0;
      @(posedge i_clk);
      clr <= 1'b0;
      ten <= 1'b1;
      @(negedge i_clk);
      wait_pend(60);
      @(negedge i_clk);
      cmp8(code, 8'hd0);
      cmp8({7'h0, n >= 14 && n <= 22}, 8'h01);
      @(posedge i_clk);
      ten <= 1'b0;
      i_rst <= 1'b1;
      repeat (16) @(posedge i_clk);
      cmp8(code, 8'hf8);
      cmp8({7'h0, pend}, 8'h00);
      cmp8(rdata, 8'h00);
      i_rst <= 1'b0;
      @(negedge i_clk);
      cmp8(code, 8'hf8);
      close_out();
   end
endmodule
`default_nettype wire
